// file: design/motion_command_decoder.sv
// Contract
// [RL1] Rotate right: velocity mode first, then velocity into target-velocity parameter.
// [RL2] Rotate left: velocity mode first, then velocity loaded, running backward.
// [RL3] Rotate right frame: instruction 1, type 0, motor 0, 32-bit velocity.
// [RL4] Rotate left frame: instruction 2, type 0, motor 0, 32-bit velocity.
// [RL5] Host keeps rotate velocity inside the controller's signed range.
// [RL6] Halt: velocity mode, then target speed parameter zero; code zeroes index 0 (target position) instead.
// [RL7] Halt frame: instruction 3, type, motor and value all zero.
// [RL8] Move replies OK at once after setup; next commands accepted immediately.
// [RL9] Move uses programmed ramp and positioning speed parameters.
// [RL10] Move operand is a full-range signed 32-bit value.
// [RL11] Move instruction 4; type 0 fixed, 1 offset, 2 stored point.
// [RL12] Host keeps actual plus offset inside the signed 32-bit range.
// [RL13] Distance beyond 2^31-1 wraps: run the shorter opposite direction.
// [RL14] Every move writes its new position into target-position parameter.
// [RL15] Stored point number in value field lies from 0 to 20.
// [RL16] Host stores a point before moving to it.
// [RL17] Halt or rotate aborts and replaces a positioning move.
// [RL18] Frame: address, instruction, type, motor, four value bytes MSB first, checksum.
// [RL19] Parameter writes live in volatile storage only.
// [RL20] Parameter write, instruction 5, stores value at parameter named by type.
// [RL21] Checksum is modulo-256 sum of eight preceding bytes, always checked.
`timescale 1ns/1ps
module motion_command_decoder (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] module_addr,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [31:0] actual_position,
  input wire logic point_wr,
  input wire logic [4:0] point_idx,
  input wire logic [31:0] point_data,
  output logic reply_valid,
  output logic [7:0] reply_status,
  output logic [31:0] reply_value,
  output logic velocity_mode,
  output logic position_mode,
  output logic run_reverse,
  output logic move_start,
  output logic [31:0] target_velocity,
  output logic [31:0] target_position,
  output logic [31:0] ramp_speed,
  output logic [31:0] ramp_accel
);
  frame_if fr ();
  param_if pb ();

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  motion_cmd_pkg::exec_state_t state;
  motion_cmd_pkg::exec_state_t next_state;
  logic [7:0] cmd;
  logic [7:0] cmd_kind;
  logic [31:0] cmd_value;
  logic [7:0] status;
  logic [31:0] point_val [motion_cmd_pkg::POINT_COUNT];
  logic [motion_cmd_pkg::POINT_COUNT-1:0] point_set;

  // True for the commands that force velocity mode
  function automatic logic is_velocity_cmd(input logic [7:0] code);
    is_velocity_cmd = code == motion_cmd_pkg::INSTR_ROTATE_RIGHT ||
                      code == motion_cmd_pkg::INSTR_ROTATE_LEFT ||
                      code == motion_cmd_pkg::INSTR_HALT;
  endfunction : is_velocity_cmd

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  frame_collector u_collector (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .slot_free(rx_ready),
    .fr(fr.collector)
  );

  axis_param_bank u_bank (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pb(pb.bank)
  );

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  wire logic addr_match = fr.addr == module_addr;
  wire logic is_rotate = fr.instr == motion_cmd_pkg::INSTR_ROTATE_RIGHT ||
                         fr.instr == motion_cmd_pkg::INSTR_ROTATE_LEFT;
  wire logic is_halt = fr.instr == motion_cmd_pkg::INSTR_HALT;
  wire logic is_move = fr.instr == motion_cmd_pkg::INSTR_MOVE;
  wire logic is_pwrite = fr.instr == motion_cmd_pkg::INSTR_PARAM_WRITE;
  wire logic is_point = fr.cmd_type == motion_cmd_pkg::STORED_POINT_TYPE;
  wire logic known = is_velocity_cmd(fr.instr) | is_move | is_pwrite;
  // [RL3] [RL4] [RL7] rotate and halt take type 0 only
  // [RL11] move types 0..2; parameter index in range
  wire logic type_bad = (is_velocity_cmd(fr.instr) && fr.cmd_type != 8'h00) ||
                        (is_move && fr.cmd_type > motion_cmd_pkg::STORED_POINT_TYPE) ||
                        (is_pwrite && fr.cmd_type >= 8'(motion_cmd_pkg::PARAM_COUNT));
  // [RL15] point number 0..20
  wire logic point_range_bad = fr.value > motion_cmd_pkg::POINT_MAX;
  // [RL16] refuse a point that was never stored
  wire logic point_unset = !point_range_bad && !point_set[fr.value[4:0]];
  // Motor byte is free only for the stored-point move
  wire logic motor_bad = fr.motor != 8'h00 && !(is_move && is_point);
  // [RL7] halt carries an all-zero value
  wire logic value_bad = motor_bad || (is_halt && fr.value != 32'h0000_0000) ||
                         (is_move && is_point && (point_range_bad || point_unset));
  wire logic [7:0] frame_status = !fr.sum_ok ? motion_cmd_pkg::STATUS_BAD_SUM :
                                  !known ? motion_cmd_pkg::STATUS_BAD_CMD :
                                  type_bad ? motion_cmd_pkg::STATUS_BAD_TYPE :
                                  value_bad ? motion_cmd_pkg::STATUS_BAD_VALUE :
                                  motion_cmd_pkg::STATUS_OK;
  wire logic frame_good = frame_status == motion_cmd_pkg::STATUS_OK;

  // Frame is consumed as soon as the sequencer is idle
  assign fr.take = state == motion_cmd_pkg::ST_IDLE && fr.pending;

  // ----------------------------------------
  // Move target arithmetic
  // ----------------------------------------
  // [RL10] operand is plain two's complement
  // [RL12] offset sum wraps silently at 32 bits
  wire logic [31:0] offset_target = actual_position + cmd_value;
  wire logic [31:0] stored_target = point_val[cmd_value[4:0]];
  wire logic [31:0] move_target =
    cmd_kind == motion_cmd_pkg::FIXED_TARGET_TYPE ? cmd_value :
    cmd_kind == motion_cmd_pkg::OFFSET_TARGET_TYPE ? offset_target : stored_target;
  // [RL13] sign of wrapped distance picks the short way
  wire logic [31:0] move_distance = move_target - actual_position;

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      motion_cmd_pkg::ST_IDLE: begin
        if (fr.pending && addr_match) begin
          next_state = frame_good ? motion_cmd_pkg::ST_MODE : motion_cmd_pkg::ST_REPLY;
        end
      end
      motion_cmd_pkg::ST_MODE: next_state = motion_cmd_pkg::ST_LOAD;
      motion_cmd_pkg::ST_LOAD: next_state = motion_cmd_pkg::ST_REPLY;
      motion_cmd_pkg::ST_REPLY: next_state = motion_cmd_pkg::ST_IDLE;
      default: next_state = motion_cmd_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Command latch and state register
  // ----------------------------------------
  // Operands held through the reply
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= motion_cmd_pkg::ST_IDLE;
      cmd <= 8'h00;
      cmd_kind <= 8'h00;
      cmd_value <= 32'h0000_0000;
      status <= motion_cmd_pkg::STATUS_OK;
    end else begin
      state <= next_state;
      if (fr.take) begin
        cmd <= fr.instr;
        cmd_kind <= fr.cmd_type;
        cmd_value <= fr.value;
        status <= frame_status;
      end else if (state == motion_cmd_pkg::ST_MODE && cmd == motion_cmd_pkg::INSTR_MOVE) begin
        cmd_value <= move_target; // Resolved new position
      end
    end
  end

  // ----------------------------------------
  // Mode selection and direction
  // ----------------------------------------
  // Halt keeps the last direction
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      velocity_mode <= 1'b0;
      position_mode <= 1'b0;
      run_reverse <= 1'b0;
    end else if (state == motion_cmd_pkg::ST_MODE) begin
      // [RL1] [RL2] [RL6] [RL17] velocity mode ends any move
      if (is_velocity_cmd(cmd)) begin
        velocity_mode <= 1'b1;
        position_mode <= 1'b0;
        if (cmd != motion_cmd_pkg::INSTR_HALT) begin
          run_reverse <= cmd == motion_cmd_pkg::INSTR_ROTATE_LEFT;
        end
      end else if (cmd == motion_cmd_pkg::INSTR_MOVE) begin
        // [RL13] direction from wrapped distance
        run_reverse <= move_distance[31];
      end
    end else if (state == motion_cmd_pkg::ST_LOAD && cmd == motion_cmd_pkg::INSTR_MOVE) begin
      velocity_mode <= 1'b0;
      position_mode <= 1'b1;
    end
  end

  // ----------------------------------------
  // Parameter write port
  // ----------------------------------------
  // [RL1] [RL2] velocity into target velocity
  // [RL6] halt zeroes index 0 (target position), not target velocity at index 2
  // [RL14] move writes target position
  // [RL20] parameter write uses type as index
  // Halt speed shares index 0 with target position
  assign pb.wr = state == motion_cmd_pkg::ST_LOAD;
  assign pb.idx = cmd == motion_cmd_pkg::INSTR_MOVE ? motion_cmd_pkg::PARAM_TARGET_POS :
                  cmd == motion_cmd_pkg::INSTR_HALT ? motion_cmd_pkg::PARAM_HALT_SPEED :
                  cmd == motion_cmd_pkg::INSTR_PARAM_WRITE ? cmd_kind[3:0] :
                  motion_cmd_pkg::PARAM_TARGET_VEL;
  assign pb.data = cmd == motion_cmd_pkg::INSTR_HALT ? 32'h0000_0000 : cmd_value;

  // ----------------------------------------
  // Move start and reply
  // ----------------------------------------
  // [RL8] reply right after setup, no wait for arrival
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      move_start <= 1'b0;
      reply_valid <= 1'b0;
      reply_status <= motion_cmd_pkg::STATUS_OK;
      reply_value <= 32'h0000_0000;
    end else begin
      move_start <= state == motion_cmd_pkg::ST_LOAD && cmd == motion_cmd_pkg::INSTR_MOVE;
      reply_valid <= state == motion_cmd_pkg::ST_REPLY;
      if (state == motion_cmd_pkg::ST_REPLY) begin
        reply_status <= status;
        reply_value <= 32'h0000_0000; // Value field unused here
      end
    end
  end

  // Parameter read-out to the motion controller
  // [RL9] ramp and positioning speed from parameters
  assign target_velocity = pb.params[motion_cmd_pkg::PARAM_TARGET_VEL];
  assign target_position = pb.params[motion_cmd_pkg::PARAM_TARGET_POS];
  assign ramp_speed = pb.params[motion_cmd_pkg::PARAM_POS_SPEED];
  assign ramp_accel = pb.params[motion_cmd_pkg::PARAM_ACCEL];

  // ----------------------------------------
  // Stored points
  // ----------------------------------------
  // Indices above 20 are ignored
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      point_set <= '0;
      for (int i = 0; i < motion_cmd_pkg::POINT_COUNT; i++) begin
        point_val[i] <= 32'h0000_0000;
      end
    end else if (point_wr && 32'(point_idx) <= motion_cmd_pkg::POINT_MAX) begin
      point_val[point_idx] <= point_data;
      point_set[point_idx] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence rot_right_mode_s;
    state == motion_cmd_pkg::ST_MODE && cmd == motion_cmd_pkg::INSTR_ROTATE_RIGHT;
  endsequence

  sequence vel_load_s;
    pb.wr && pb.idx == motion_cmd_pkg::PARAM_TARGET_VEL;
  endsequence

  right_mode_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL1]
    rot_right_mode_s |=> velocity_mode && !run_reverse ##0 vel_load_s
      ##1 target_velocity == $past(cmd_value))
    else $error("rotate right mode or load wrong");

  left_reverse_run_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL2]
    state == motion_cmd_pkg::ST_MODE && cmd == motion_cmd_pkg::INSTR_ROTATE_LEFT
      |=> velocity_mode && run_reverse && pb.wr)
    else $error("rotate left not reversed");

  halt_zero_speed_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL6]
    state == motion_cmd_pkg::ST_LOAD && cmd == motion_cmd_pkg::INSTR_HALT
      |-> velocity_mode && pb.wr && pb.idx == motion_cmd_pkg::PARAM_HALT_SPEED &&
          pb.data == 32'h0000_0000)
    else $error("halt did not zero speed");

  move_reply_ok_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL8]
    move_start |-> position_mode ##1 reply_valid &&
      reply_status == motion_cmd_pkg::STATUS_OK ##1 state == motion_cmd_pkg::ST_IDLE)
    else $error("move reply late or wrong");

  abort_move_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL17]
    position_mode && state == motion_cmd_pkg::ST_MODE && is_velocity_cmd(cmd)
      |=> !position_mode)
    else $error("move not aborted");

  target_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL14]
    state == motion_cmd_pkg::ST_LOAD && cmd == motion_cmd_pkg::INSTR_MOVE
      |=> target_position == $past(cmd_value) && move_start)
    else $error("target position not written");

  wrap_direction_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL13]
    state == motion_cmd_pkg::ST_MODE && cmd == motion_cmd_pkg::INSTR_MOVE
      |=> run_reverse == $past(move_distance[31]))
    else $error("move direction wrong");

  bad_sum_reply_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL21]
    fr.take && addr_match && !fr.sum_ok
      |=> state == motion_cmd_pkg::ST_REPLY ##1 reply_valid &&
          reply_status == motion_cmd_pkg::STATUS_BAD_SUM)
    else $error("checksum error not reported");

  point_range_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RL15]
    fr.take && addr_match && fr.sum_ok && is_move && is_point && point_range_bad
      |-> ##2 reply_valid && reply_status == motion_cmd_pkg::STATUS_BAD_VALUE)
    else $error("point number not checked");

  param_index_a: assert property (state == motion_cmd_pkg::ST_LOAD && // [RL20]
    cmd == motion_cmd_pkg::INSTR_PARAM_WRITE
      |=> pb.params[$past(cmd_kind[3:0])] == $past(cmd_value))
    else $error("parameter write misrouted");

  // Rotate frames past the checksum
  sequence rotate_frame_s;
    fr.take && addr_match && fr.sum_ok && is_rotate;
  endsequence

  rotate_type_a: assert property (rotate_frame_s ##0 fr.cmd_type != 8'h00 // [RL4]
    |=> state == motion_cmd_pkg::ST_REPLY
      ##1 reply_status == motion_cmd_pkg::STATUS_BAD_TYPE)
    else $error("rotate type not refused");

  halt_value_a: assert property (fr.take && addr_match && fr.sum_ok && is_halt && // [RL7]
    fr.cmd_type == 8'h00 && fr.value != 32'h0000_0000
      |-> ##2 reply_valid &&
      reply_status == motion_cmd_pkg::STATUS_BAD_VALUE)
    else $error("halt value not refused");
endmodule : motion_command_decoder

// file: design/motion_cmd_pkg.sv
package motion_cmd_pkg;
  // ----------------------------------------
  // Frame layout and instruction codes
  // ----------------------------------------
  localparam int FRAME_BYTES = 9;
  localparam logic [3:0] LAST_BYTE = 4'h8;
  localparam logic [7:0] INSTR_ROTATE_RIGHT = 8'h01;
  localparam logic [7:0] INSTR_ROTATE_LEFT = 8'h02;
  localparam logic [7:0] INSTR_HALT = 8'h03;
  localparam logic [7:0] INSTR_MOVE = 8'h04;
  localparam logic [7:0] INSTR_PARAM_WRITE = 8'h05;
  // Move target kinds
  localparam logic [7:0] FIXED_TARGET_TYPE = 8'h00;
  localparam logic [7:0] OFFSET_TARGET_TYPE = 8'h01;
  localparam logic [7:0] STORED_POINT_TYPE = 8'h02;
  // ----------------------------------------
  // Reply status codes
  // ----------------------------------------
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  // ----------------------------------------
  // Axis parameters and stored points
  // ----------------------------------------
  localparam int PARAM_COUNT = 16;
  localparam logic [3:0] PARAM_TARGET_POS = 4'h0;
  localparam logic [3:0] PARAM_HALT_SPEED = 4'h0;
  localparam logic [3:0] PARAM_TARGET_VEL = 4'h2;
  localparam logic [3:0] PARAM_POS_SPEED = 4'h4;
  localparam logic [3:0] PARAM_ACCEL = 4'h5;
  localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
  localparam int POINT_COUNT = 21;
  localparam logic [31:0] POINT_MAX = 32'h0000_0014;
  // ----------------------------------------
  // Command sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MODE = 2'b01,
    ST_LOAD = 2'b10,
    ST_REPLY = 2'b11
  } exec_state_t;
endpackage : motion_cmd_pkg

// file: design/cmd_links_if.sv
`timescale 1ns/1ps
// Completed frame handed from the byte collector to the sequencer
interface frame_if;
  logic pending;
  logic take;
  logic sum_ok;
  logic [7:0] addr;
  logic [7:0] instr;
  logic [7:0] cmd_type;
  logic [7:0] motor;
  logic [31:0] value;
  modport collector (output pending, sum_ok, addr, instr, cmd_type, motor, value, input take);
  modport sequencer (input pending, sum_ok, addr, instr, cmd_type, motor, value, output take);
endinterface : frame_if

// Write port and read-out of the axis parameter bank
interface param_if;
  logic wr;
  logic [3:0] idx;
  logic [31:0] data;
  logic [31:0] params [motion_cmd_pkg::PARAM_COUNT];
  modport bank (input wr, idx, data, output params);
  modport user (output wr, idx, data, input params);
endinterface : param_if

// file: design/frame_collector.sv
`timescale 1ns/1ps
module frame_collector (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic slot_free,
  frame_if.collector fr
);
  logic [3:0] byte_cnt;
  logic [7:0] sum;
  wire logic accept = rx_valid & slot_free;
  wire logic last = byte_cnt == motion_cmd_pkg::LAST_BYTE;

  assign fr.pending = ~slot_free;

  // ----------------------------------------
  // Byte collection
  // ----------------------------------------
  // [RL18] fixed field order, value MSB first
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      byte_cnt <= 4'h0;
      sum <= 8'h00;
      slot_free <= 1'b1;
      fr.sum_ok <= 1'b0;
      fr.addr <= 8'h00;
      fr.instr <= 8'h00;
      fr.cmd_type <= 8'h00;
      fr.motor <= 8'h00;
      fr.value <= 32'h0000_0000;
    end else if (accept) begin
      byte_cnt <= last ? 4'h0 : byte_cnt + 4'h1;
      sum <= last ? 8'h00 : sum + rx_byte;
      case (byte_cnt)
        4'h0: fr.addr <= rx_byte;
        4'h1: fr.instr <= rx_byte;
        4'h2: fr.cmd_type <= rx_byte;
        4'h3: fr.motor <= rx_byte;
        4'h8: begin
          // [RL21] modulo-256 checksum compare
          fr.sum_ok <= sum == rx_byte;
          slot_free <= 1'b0;
        end
        default: fr.value <= {fr.value[23:0], rx_byte};
      endcase
    end else if (fr.take) begin
      slot_free <= 1'b1;
    end
  end

  // [RL21] checksum verdict
  sum_verdict_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    accept && last |=> fr.sum_ok == ($past(sum) == $past(rx_byte)) && !slot_free)
    else $error("checksum verdict wrong");
endmodule : frame_collector

// file: design/axis_param_bank.sv
`timescale 1ns/1ps
module axis_param_bank (
  input wire logic clk_sys,
  input wire logic reset_n,
  param_if.bank pb
);
  // ----------------------------------------
  // Volatile parameter storage
  // ----------------------------------------
  // [RL19] flip-flops only, cleared by reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < motion_cmd_pkg::PARAM_COUNT; i++) begin
        pb.params[i] <= motion_cmd_pkg::PARAM_RESET;
      end
    end else if (pb.wr) begin
      // [RL20] write selected parameter
      pb.params[pb.idx] <= pb.data;
    end
  end

  // [RL20] write lands
  param_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pb.wr |=> pb.params[$past(pb.idx)] == $past(pb.data))
    else $error("parameter write lost");
endmodule : axis_param_bank

// file: tb/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  input wire logic clk_sys,
  input wire logic rx_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  logic [7:0] frame [9];
  int gap = 0;

  // Link idle at time zero
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end

  // ----------------------------------------
  // Frame sender, bytes held until taken
  // ----------------------------------------
  task automatic send(input logic [7:0] adr, ins, typ, mot, input logic [31:0] val,
                      input logic [7:0] sum_err, output bit hung);
    logic [7:0] sum;
    hung = 1'b0;
    frame = '{adr, ins, typ, mot, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum = sum + frame[i];
    frame[8] = sum ^ sum_err;
    for (int i = 0; i < 9; i++) begin
      repeat (gap) begin
        @(negedge clk_sys);
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
      end
      @(negedge clk_sys);
      rx_byte = frame[i];
      rx_valid = 1'b1;
      for (int w = 0; w < 40 && rx_ready !== 1'b1; w++) @(negedge clk_sys);
      if (rx_ready !== 1'b1) hung = 1'b1;
      @(posedge clk_sys);
    end
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask : send
endmodule : host_link_model

// file: tb/motion_command_decoder_bench.sv
`timescale 1ns/1ps
module motion_command_decoder_bench;
  logic clk_sys, reset_n, rx_ready, rx_valid, point_wr, reply_valid;
  logic velocity_mode, position_mode, run_reverse, move_start;
  logic [7:0] module_addr, rx_byte, reply_status, st;
  logic [4:0] point_idx;
  logic [31:0] actual_position, point_data, reply_value, v, pos;
  logic [31:0] target_velocity, target_position, ramp_speed, ramp_accel;
  int bad_count = 0;
  int checks_done = 0;
  int starts = 0;
  int replies = 0;
  int n;
  bit got, hung;

  motion_command_decoder dut (.clk_sys, .reset_n, .module_addr, .rx_byte, .rx_valid,
    .rx_ready, .actual_position, .point_wr, .point_idx, .point_data, .reply_valid,
    .reply_status, .reply_value, .velocity_mode, .position_mode, .run_reverse,
    .move_start, .target_velocity, .target_position, .ramp_speed, .ramp_accel);
  host_link_model host (.clk_sys, .rx_ready, .rx_byte, .rx_valid);

  // Free running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Pulse counters sampled mid-cycle
  always @(negedge clk_sys) begin
    if (move_start === 1'b1) starts++;
    if (reply_valid === 1'b1) replies++;
  end

  // Direction of the shorter wrapped path
  function automatic logic exp_rev(input logic [31:0] nxt, act);
    logic [31:0] d;
    d = nxt - act;
    return d[31];
  endfunction : exp_rev

  task automatic check(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Send one frame and wait a bounded time for its reply
  task automatic cmd(input logic [7:0] adr, ins, typ, mot, input logic [31:0] val,
                     input logic [7:0] err);
    host.send(adr, ins, typ, mot, val, err, hung);
    got = 1'b0;
    for (int w = 0; w < 12 && !got; w++) begin
      @(negedge clk_sys);
      got = (reply_valid === 1'b1);
    end
    st = reply_status;
    if (hung) begin
      bad_count++;
      finish_test();
    end
  endtask : cmd

  task automatic run(input logic [7:0] ins, typ, mot, input logic [31:0] val);
    cmd(module_addr, ins, typ, mot, val, 8'h00);
    check("reply", got, 1);
    check("reply_value", reply_value, 0);
    if (!got) finish_test();
  endtask : run

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    v = $urandom(32'h00cb);
    reset_n = 1'b0;
    module_addr = 8'h01;
    actual_position = 32'h0000_0000;
    point_wr = 1'b0;
    point_idx = 5'h00;
    point_data = 32'h0000_0000;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    check("ready", rx_ready, 1);
    check("status_rst", reply_status, motion_cmd_pkg::STATUS_OK);
    // velocities kept within the legal signed range
    for (int k = 0; k < 6; k++) begin
      v = $urandom_range(4094) - 2047;
      host.gap = k % 3;
      run(k[0] ? motion_cmd_pkg::INSTR_ROTATE_LEFT : motion_cmd_pkg::INSTR_ROTATE_RIGHT,
          8'h00, 8'h00, v);
      check("rot_status", st, motion_cmd_pkg::STATUS_OK);
      check("rot_mode", {velocity_mode, position_mode}, 2'b10);
      check("rot_dir", run_reverse, k[0]);
      check("rot_vel", target_velocity, v);
    end
    v = $urandom | 32'h1;
    pos = $urandom;
    run(motion_cmd_pkg::INSTR_PARAM_WRITE, {4'h0, motion_cmd_pkg::PARAM_POS_SPEED}, 8'h00, v);
    run(motion_cmd_pkg::INSTR_PARAM_WRITE, {4'h0, motion_cmd_pkg::PARAM_ACCEL}, 8'h00, pos);
    check("ramp_speed", ramp_speed, v);
    check("ramp_accel", ramp_accel, pos);
    // a random fixed move, two fixed moves across the wrap, then an offset move inside the signed range
    for (int k = 0; k < 4; k++) begin
      @(negedge clk_sys);
      actual_position = (k == 1) ? 32'h7fff_fff0 : (k == 2) ? 32'h8000_0010 :
                        $urandom_range(32'h000f_ffff);
      v = (k == 1) ? 32'h8000_0010 : (k == 2) ? 32'h7fff_fff0 :
          (k == 3) ? $urandom_range(32'hffff) - 32'h8000 : $urandom;
      pos = (k == 3) ? actual_position + v : v;
      n = starts;
      run(motion_cmd_pkg::INSTR_MOVE, (k == 3) ? motion_cmd_pkg::OFFSET_TARGET_TYPE :
          motion_cmd_pkg::FIXED_TARGET_TYPE, 8'h00, v);
      check("mv_status", st, motion_cmd_pkg::STATUS_OK);
      check("mv_target", target_position, pos);
      check("mv_dir", run_reverse, exp_rev(pos, actual_position));
      check("mv_mode", {velocity_mode, position_mode}, 2'b01);
      check("mv_start", starts - n, 1);
    end
    // point stored before it is used
    @(negedge clk_sys);
    point_wr = 1'b1;
    point_idx = 5'd20;
    point_data = $urandom;
    @(negedge clk_sys);
    point_wr = 1'b0;
    run(motion_cmd_pkg::INSTR_MOVE, motion_cmd_pkg::STORED_POINT_TYPE,
        8'($urandom_range(255)), 20);
    check("pt_target", target_position, point_data);
    run(motion_cmd_pkg::INSTR_MOVE, motion_cmd_pkg::STORED_POINT_TYPE, 8'h00, 32'd21);
    check("pt_range", st, motion_cmd_pkg::STATUS_BAD_VALUE);
    run(motion_cmd_pkg::INSTR_MOVE, motion_cmd_pkg::STORED_POINT_TYPE, 8'h00, 32'd3);
    check("pt_unset", st, motion_cmd_pkg::STATUS_BAD_VALUE);
    check("pt_kept", target_position, point_data);
    run(motion_cmd_pkg::INSTR_HALT, 8'h00, 8'h00, 32'h0);
    check("halt_mode", {velocity_mode, position_mode}, 2'b10);
    check("halt_zero", target_position, 0);
    v = target_velocity;
    cmd(module_addr, motion_cmd_pkg::INSTR_ROTATE_RIGHT, 8'h00, 8'h00, 32'd5, 8'h01);
    check("bad_sum", st, motion_cmd_pkg::STATUS_BAD_SUM);
    check("sum_kept", target_velocity, v);
    run(8'h09, 8'h00, 8'h00, 32'h0);
    check("bad_cmd", st, motion_cmd_pkg::STATUS_BAD_CMD);
    run(motion_cmd_pkg::INSTR_MOVE, 8'h03, 8'h00, 32'h0);
    check("bad_type", st, motion_cmd_pkg::STATUS_BAD_TYPE);
    run(motion_cmd_pkg::INSTR_ROTATE_LEFT, 8'h01, 8'h00, 32'h0);
    check("rot_type", st, motion_cmd_pkg::STATUS_BAD_TYPE);
    run(motion_cmd_pkg::INSTR_HALT, 8'h00, 8'h00, 32'h1);
    check("halt_value", st, motion_cmd_pkg::STATUS_BAD_VALUE);
    cmd(module_addr + 8'h01, motion_cmd_pkg::INSTR_HALT, 8'h00, 8'h00, 32'h0, 8'h00);
    check("other_addr", got, 0);
    // Move followed at once by a rotate, no wait for the move reply
    n = replies;
    host.send(module_addr, motion_cmd_pkg::INSTR_MOVE, 8'h00, 8'h00, 32'h1000, 8'h00, hung);
    host.send(module_addr, motion_cmd_pkg::INSTR_ROTATE_LEFT, 8'h00, 8'h00, 100, 8'h00, hung);
    for (int w = 0; w < 20 && replies - n < 2; w++) @(negedge clk_sys);
    check("two_replies", replies - n, 2);
    check("hung", hung, 0);
    if (hung || replies - n != 2) finish_test();
    check("abort", {velocity_mode, position_mode, run_reverse}, 3'b101);
    @(negedge clk_sys);
    reset_n = 1'b0;
    @(negedge clk_sys);
    reset_n = 1'b1;
    check("volatile", ramp_speed, 0);
    finish_test();
  end
endmodule : motion_command_decoder_bench
